//--- bench/eep_master_model.sv
`timescale 1ns/10ps
module eep_master_model
   import eep_pkg::*;
(
   // serial link driven
   output logic sck_clk,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   // serial link watched
   input wire logic so,
   input wire logic so_oe
);
   logic cpol;
   logic paused_oe;
   logic idle_oe;
   logic [7:0] rx_byte;
   event got_byte;
   // released output is seen as floating, so a missing drive never matches
   wire so_w = so_oe ? so : 1'bZ;

   initial
   begin
      cpol = 1'b0;
      sck_clk = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      // select rises with the supply, so the link flops see one clearing edge
      #2;
      cs_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bits change at the falling edge and are caught at the rising one
   task automatic xfer(input logic [7:0] tx, input logic pause, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sck_clk = 1'b0;
         si = tx[i];
         #7.5;
         if (pause && i == 3)
         begin
            hold_n = 1'b0;
            #7.5;
            paused_oe = so_oe;
            // even count, so the clock is low again at release
            repeat (6)
            begin
               sck_clk = ~sck_clk;
               si = ~si;
               #7.5;
               paused_oe = paused_oe | so_oe;
            end
            si = tx[i];
            hold_n = 1'b1;
            #7.5;
         end
         sck_clk = 1'b1;
         rx[i] = so_w;
         #7.5;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // gap before each frame keeps select high long enough
   task automatic frame_open();
      #120;
      sck_clk = cpol;
      #7.5;
      cs_n = 1'b0;
      #7.5;
   endtask

   task automatic frame_close();
      sck_clk = cpol;
      #7.5;
      cs_n = 1'b1;
      si = ~si;
   endtask

   task automatic write_frame(input logic [8:0] a, input logic [7:0] d[$]);
      logic [7:0] rx;
      frame_open();
      xfer(EEP_OP_WRITE | 8'({a[8], 3'h0}), 1'b0, rx);
      xfer(a[7:0], 1'b0, rx);
      foreach (d[k])
         xfer(d[k], 1'b0, rx);
      frame_close();
   endtask

   task automatic read_frame(input logic [8:0] a, input int n, input logic pause);
      logic [7:0] rx;
      frame_open();
      xfer(EEP_OP_READ | 8'({a[8], 3'h0}), 1'b0, rx);
      xfer(a[7:0], 1'b0, rx);
      xfer(8'h00, 1'b0, rx);
      for (int k = 0; k < n; k++)
      begin
         xfer(8'h00, pause && k == 0, rx);
         rx_byte = rx;
         -> got_byte;
      end
      frame_close();
   endtask

   // traffic while deselected
   task automatic noise();
      idle_oe = 1'b0;
      repeat (16)
      begin
         si = ~si;
         sck_clk = ~sck_clk;
         #7.5;
         idle_oe = idle_oe | so_oe;
      end
      sck_clk = cpol;
   endtask
endmodule

//--- bench/spi_eeprom_pin_interface_bench.sv
`timescale 1ns/10ps
module spi_eeprom_pin_interface_bench;
   import eep_pkg::*;
   // short write cycle keeps the run small
   localparam int WR = 20;
   logic sys_clk;
   logic resetn;
   logic ce;
   logic wp_n;
   logic sck_clk;
   logic cs_n;
   logic si;
   logic hold_n;
   logic so;
   logic so_oe;
   logic wr_busy;
   logic [7:0] exp_mem [EEP_MEM_WORDS];
   logic [7:0] exp_q [$];
   logic [31:0] seed = 32'h9BAC01B1;
   int num_errors = 0;
   int check_count = 0;

   eep_spi_front #(.MEM_WORDS(EEP_MEM_WORDS), .WR_CYCLES(WR)) uut (
      .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
      .sck_clk(sck_clk), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
      .so(so), .so_oe(so_oe), .wr_busy(wr_busy)
   );

   eep_master_model m (
      .sck_clk(sck_clk), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .so(so), .so_oe(so_oe)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic read_chk(input logic [8:0] a, input int n, input logic pause);
      for (int k = 0; k < n; k++)
         exp_q.push_back(exp_mem[9'(a + 9'(k))]);
      m.read_frame(a, n, pause);
      @(negedge sys_clk);
   endtask

   // mode 0 plain, 1 protect low, 2 protect pulse mid-frame, 3 protect low while busy
   task automatic do_write(input logic [8:0] a, input int n, input int mode);
      logic [7:0] d[$];
      int t;
      for (int k = 0; k < n; k++)
      begin
         seed = xs(seed);
         d.push_back(seed[7:0]);
      end
      if (mode == 1)
         wp_n = 1'b0;
      if (mode == 2)
         fork
            m.write_frame(a, d);
            begin
               repeat (30) @(negedge sys_clk);
               wp_n = 1'b0;
               repeat (3) @(negedge sys_clk);
               wp_n = 1'b1;
            end
         join
      else
         m.write_frame(a, d);
      @(negedge sys_clk);
      t = 0;
      while (wr_busy !== 1'b1 && t < 30)
      begin
         @(negedge sys_clk);
         t++;
      end
      check("write start", wr_busy, 1'(mode == 0 || mode == 3));
      if (wr_busy === 1'b1)
      begin
         if (mode == 3)
            wp_n = 1'b0;
         t = 0;
         while (wr_busy === 1'b1 && t < WR + 50)
         begin
            // a five-cycle stall of the enable must stretch the write cycle
            ce = !(mode == 3 && t >= 2 && t < 7);
            @(negedge sys_clk);
            t++;
         end
         ce = 1'b1;
         check("busy length", t, (mode == 3) ? WR + 5 : WR);
         if (t >= WR + 50)
            finish_test();
         // page wrap inside eight bytes
         for (int k = 0; k < n; k++)
            exp_mem[{a[8:3], 3'(a[2:0] + 3'(k))}] = d[k];
      end
      wp_n = 1'b1;
   endtask

   always @(m.got_byte)
   begin
      if (exp_q.size() == 0)
         check("read extra", 1, 0);
      else
         check("read byte", m.rx_byte, exp_q.pop_front());
   end

   initial
   begin
      #1000000;
      num_errors++;
      $display("BAD timeout expected done seen hang");
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      wp_n = 1'b1;
      foreach (exp_mem[i])
         exp_mem[i] = EEP_ERASED;
      repeat (8) @(negedge sys_clk);
      check("oe in reset", so_oe, 1'b0);
      resetn = 1'b1;
      repeat (6) @(negedge sys_clk);
      read_chk(9'h1FE, 4, 1'b0);
      do_write(9'h105, 4, 0);
      read_chk(9'h100, 8, 1'b0);
      m.cpol = 1'b1;
      read_chk(9'h104, 3, 1'b0);
      do_write(9'h1F0, 2, 0);
      m.cpol = 1'b0;
      do_write(9'h0A0, 2, 1);
      do_write(9'h0A8, 3, 2);
      do_write(9'h0B3, 2, 3);
      read_chk(9'h0A0, 24, 1'b0);
      read_chk(9'h1F0, 2, 1'b1);
      check("paused oe", m.paused_oe, 1'b0);
      m.noise();
      @(negedge sys_clk);
      check("idle oe", m.idle_oe, 1'b0);
      read_chk(9'h0B3, 2, 1'b0);
      check("queue left", exp_q.size(), 0);
      finish_test();
   end
endmodule

//--- verilog/eep_pkg.sv
package eep_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // array and framing
   localparam int EEP_DATA_W = 8;
   localparam int EEP_MEM_WORDS = 512;
   localparam int EEP_PAGE_BYTES = 8;
   localparam logic [7:0] EEP_ERASED = 8'hFF;
   localparam logic [2:0] EEP_BIT_RST = 3'h0;
   localparam logic [2:0] EEP_BIT_LAST = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // instruction bytes; bit 3 carries the top address bit on the largest array
   localparam logic [7:0] EEP_OP_MASK = 8'hF7;
   localparam logic [7:0] EEP_OP_READ = 8'h03;
   localparam logic [7:0] EEP_OP_WRITE = 8'h02;
   localparam int EEP_OP_A8_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // self-timed write: longest time, so the cycle count rounds down
   localparam int EEP_SYS_PERIOD_NS = 10;
   localparam int EEP_TWR_MAX_NS = 5000000;
   localparam int EEP_TWR_CYCLES = EEP_TWR_MAX_NS / EEP_SYS_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // sequence position, kept in the system clock domain
   typedef enum logic [2:0] {
      SEQ_OPCODE,
      SEQ_ADDR,
      SEQ_DUMMY,
      SEQ_RDATA,
      SEQ_WDATA,
      SEQ_IGNORE
   } eep_seq_e;

endpackage

//--- verilog/eep_spi_front.sv
`timescale 1ns/10ps
// Notes on behaviour
// - device takes part in transfers only while chip select is low.
// - deselected: serial input ignored, serial output released.
// - serial input sampled on each rising serial clock edge.
// - read data driven onto serial output after each falling edge.
// - write-protect high lets reads and writes proceed normally.
// - write-protect low blocks every write.
// - write-protect falling during a selected write sequence aborts that write.
// - a started self-timed write cycle completes regardless of write-protect.
// - suspend pauses a selected sequence, keeping its position and contents.
// - suspend released while clock low; clock edges during pause are ignored.
// - while paused, input ignored and output released.
// - array of 128, 256 or 512 bytes with matching address width.
// - clock modes 0 and 3 both work.
module eep_spi_front
   import eep_pkg::*;
#(
   parameter int MEM_WORDS = EEP_MEM_WORDS,
   parameter int WR_CYCLES = EEP_TWR_CYCLES,
   parameter int ADDR_W = $clog2(MEM_WORDS)
)
(
   // system clock
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ce,
   // serial link
   input wire logic sck_clk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic so,
   output logic so_oe,
   // status
   output logic wr_busy
);

   localparam int PG_W = $clog2(EEP_PAGE_BYTES);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic link_rst_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] rx_byte_r;
   logic rx_tgl_r;
   logic [7:0] tx_sh_r;
   logic en_m_r;
   logic en_s_r;
   logic so_r;
   logic so_oe_r;
   logic tx_next_bit;

   logic cs_s;
   logic wp_s;
   logic tgl_s;
   logic cs_q_r;
   logic tgl_q_r;
   logic armed_r;
   eep_seq_e st_r;
   logic rd_op_r;
   logic op_hi_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] tx_data_r;
   logic tx_en_r;
   logic wp_abort_r;
   logic [EEP_PAGE_BYTES-1:0] pg_vld_r;
   logic [7:0] pg_buf [EEP_PAGE_BYTES];
   logic [7:0] mem [MEM_WORDS];

   logic sel_w;
   logic frame_end_w;
   logic byte_evt_w;
   logic op_rd_w;
   logic op_wr_w;
   logic wr_seq_w;
   logic wr_start_w;
   logic wr_done_w;
   logic [ADDR_W-1:0] new_addr_w;
   logic [ADDR_W-1:0] inc_addr_w;
   logic [ADDR_W-1:0] pg_addr_w;

   ////////////////////////////////////////////////////////////////////////////
   // link domain, input side: a deselect clears the shifter at once
   always_ff @(posedge sck_clk or posedge cs_n)
   begin
      if (cs_n)
      begin
         bit_cnt_r <= EEP_BIT_RST;
         rx_sh_r <= '0;
      end
      else if (hold_n)
      begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_sh_r <= {rx_sh_r[6:0], si};
      end
   end

   // the toggle survives deselect so the system side never sees a false byte
   always_ff @(posedge sck_clk or posedge link_rst_r)
   begin
      if (link_rst_r)
      begin
         rx_byte_r <= '0;
         rx_tgl_r <= 1'b0;
      end
      else if (!cs_n && hold_n && bit_cnt_r == EEP_BIT_LAST)
      begin
         rx_byte_r <= {rx_sh_r[6:0], si};
         rx_tgl_r <= ~rx_tgl_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain, output side; a mode 3 leading fall only preloads
   always_ff @(negedge sck_clk or posedge cs_n)
   begin
      if (cs_n)
      begin
         en_m_r <= 1'b0;
         en_s_r <= 1'b0;
         tx_sh_r <= '0;
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
      end
      else if (hold_n)
      begin
         en_m_r <= tx_en_r;
         en_s_r <= en_m_r;
         so_oe_r <= en_s_r;
         if (bit_cnt_r == EEP_BIT_RST)
         begin
            tx_sh_r <= tx_data_r;
            so_r <= tx_data_r[7];
         end
         else
         begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            so_r <= tx_next_bit;
         end
      end
   end

   assign tx_next_bit = tx_sh_r[6];
   assign so = so_r;
   // suspend releases the pin at once, not at the next clock edge
   assign so_oe = so_oe_r & hold_n;

   ////////////////////////////////////////////////////////////////////////////
   // crossings into the system domain
   eep_sync2 #(.W(2), .RST_VAL(2'b11)) u_sync_pins (
      .clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .d({cs_n, wp_n}),
      .q({cs_s, wp_s})
   );

   // rx_byte_r is stable for eight clocks after each toggle, ample to sample
   eep_sync2 #(.W(1), .RST_VAL(1'b0)) u_sync_tgl (
      .clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .d(rx_tgl_r),
      .q(tgl_s)
   );

   always_ff @(posedge sys_clk)
   begin
      link_rst_r <= !resetn;
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode
   assign sel_w = !cs_s;
   assign frame_end_w = cs_s && !cs_q_r;
   assign byte_evt_w = (tgl_s != tgl_q_r) && sel_w && armed_r;
   assign op_rd_w = (rx_byte_r & EEP_OP_MASK) == EEP_OP_READ;
   assign op_wr_w = (rx_byte_r & EEP_OP_MASK) == EEP_OP_WRITE;
   assign new_addr_w = ADDR_W'({op_hi_r, rx_byte_r});
   assign inc_addr_w = addr_r + ADDR_W'(1);
   assign pg_addr_w = {addr_r[ADDR_W-1:PG_W], addr_r[PG_W-1:0] + PG_W'(1)};
   assign wr_seq_w = sel_w && (st_r == SEQ_WDATA || (st_r == SEQ_ADDR && !rd_op_r));
   assign wr_start_w = ce && frame_end_w && st_r == SEQ_WDATA && (|pg_vld_r)
      && wp_s && !wp_abort_r;

   ////////////////////////////////////////////////////////////////////////////
   // sequence control
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         cs_q_r <= 1'b1;
         tgl_q_r <= 1'b0;
         armed_r <= 1'b0;
         st_r <= SEQ_OPCODE;
         rd_op_r <= 1'b0;
         op_hi_r <= 1'b0;
         addr_r <= '0;
         tx_data_r <= '0;
         tx_en_r <= 1'b0;
         wp_abort_r <= 1'b0;
         pg_vld_r <= '0;
      end
      else if (ce)
      begin
         cs_q_r <= cs_s;
         tgl_q_r <= tgl_s;
         if (cs_s)
            armed_r <= 1'b1;
         if (wr_seq_w && !wp_s)
            wp_abort_r <= 1'b1;
         if (frame_end_w)
         begin
            st_r <= SEQ_OPCODE;
            tx_en_r <= 1'b0;
            wp_abort_r <= 1'b0;
            pg_vld_r <= '0;
         end
         else if (byte_evt_w)
         begin
            case (st_r)
               SEQ_OPCODE:
               begin
                  rd_op_r <= op_rd_w;
                  op_hi_r <= rx_byte_r[EEP_OP_A8_BIT];
                  st_r <= (wr_busy || !(op_rd_w || op_wr_w)) ? SEQ_IGNORE : SEQ_ADDR;
               end
               SEQ_ADDR:
               begin
                  addr_r <= new_addr_w;
                  // reads are never gated by write-protect
                  tx_data_r <= mem[new_addr_w];
                  tx_en_r <= rd_op_r;
                  st_r <= rd_op_r ? SEQ_DUMMY : SEQ_WDATA;
               end
               SEQ_DUMMY, SEQ_RDATA:
               begin
                  addr_r <= inc_addr_w;
                  tx_data_r <= mem[inc_addr_w];
                  st_r <= SEQ_RDATA;
               end
               SEQ_WDATA:
               begin
                  pg_vld_r[addr_r[PG_W-1:0]] <= 1'b1;
                  addr_r <= pg_addr_w;
               end
               default:
                  st_r <= SEQ_IGNORE;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (ce && byte_evt_w && st_r == SEQ_WDATA)
         pg_buf[addr_r[PG_W-1:0]] <= rx_byte_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // array: the page is committed when the write cycle starts
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < MEM_WORDS; i++)
            mem[i] <= EEP_ERASED;
      end
      else if (wr_start_w)
      begin
         for (int i = 0; i < EEP_PAGE_BYTES; i++)
            if (pg_vld_r[i])
               mem[{addr_r[ADDR_W-1:PG_W], PG_W'(i)}] <= pg_buf[i];
      end
   end

   eep_wr_timer #(.CYCLES(WR_CYCLES)) u_wr_timer (
      .clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .start(wr_start_w),
      .busy(wr_busy),
      .done(wr_done_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_desel_out_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      cs_n |-> !so_oe) else $error("serial output driven while deselected");
   a_hold_out_off: assert property (@(posedge sys_clk) disable iff (!resetn)
      !hold_n |-> !so_oe) else $error("serial output driven while paused");
   a_rise_count: assert property (@(posedge sck_clk) disable iff (cs_n)
      hold_n |=> bit_cnt_r == 3'($past(bit_cnt_r) + 3'h1))
      else $error("bit counter missed a rising edge");
   a_hold_freeze: assert property (@(posedge sck_clk) disable iff (cs_n)
      !hold_n |=> $stable(bit_cnt_r) && $stable(rx_sh_r))
      else $error("sequence moved while paused");
   a_fall_shift: assert property (@(negedge sck_clk) disable iff (cs_n)
      (hold_n && bit_cnt_r != EEP_BIT_RST) |=> so == $past(tx_next_bit))
      else $error("output bit not shifted on falling edge");
   a_wp_start_ok: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(wr_busy) |-> $past(wp_s) && !$past(wp_abort_r))
      else $error("write started while protected");
   a_wp_abort_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ce && wr_seq_w && !wp_s) |=> wp_abort_r || frame_end_w)
      else $error("write not aborted on protect");
   a_wr_runs_out: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wr_busy && !wp_s) |=> wr_busy || wr_done_w)
      else $error("write cycle cut short");
   a_desel_rearm: assert property (@(posedge sys_clk) disable iff (!resetn)
      cs_n |-> bit_cnt_r == EEP_BIT_RST) else $error("shifter not cleared");
   a_sel_events: assert property (@(posedge sck_clk) disable iff (link_rst_r)
      cs_n |=> $stable(rx_tgl_r)) else $error("byte taken while idle");

   c_read_stream: cover property (@(posedge sys_clk) disable iff (!resetn)
      byte_evt_w && st_r == SEQ_RDATA);
   c_write_start: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(wr_busy));
   c_paused: cover property (@(posedge sck_clk) disable iff (cs_n) !hold_n);
   c_wp_abort: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(wp_abort_r));

endmodule

//--- verilog/eep_sync2.sv
`timescale 1ns/10ps
module eep_sync2
   import eep_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // clock and control
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         meta_r <= RST_VAL;
         q_r <= RST_VAL;
      end
      else if (ce)
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule

//--- verilog/eep_wr_timer.sv
`timescale 1ns/10ps
module eep_wr_timer
   import eep_pkg::*;
#(
   parameter int CYCLES = EEP_TWR_CYCLES,
   parameter int CNT_W = $clog2(CYCLES + 1)
)
(
   // clock and control
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // write cycle
   input wire logic start,
   output logic busy,
   output logic done
);

   logic [CNT_W-1:0] cnt_r;
   logic busy_r;
   logic done_r;

   // a start while busy is dropped; the running cycle always finishes
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (ce)
      begin
         done_r <= 1'b0;
         if (start && !busy_r)
         begin
            busy_r <= 1'b1;
            cnt_r <= CNT_W'(CYCLES - 1);
         end
         else if (busy_r && cnt_r == '0)
         begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end
         else if (busy_r)
         begin
            cnt_r <= cnt_r - CNT_W'(1);
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;

endmodule
